// File: core/tws_device.sv
`timescale 1ns/100ps
`include "tws_map.svh"
module tws_device (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  // link
  tws_if.dev link
);
  import tws_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] half_of(input logic [7:0] ctrl);
    if (ctrl[`TWS_CTRL_RATE_HIGH]) begin
      return `TWS_HALF_RATE2;
    end else if (ctrl[`TWS_CTRL_RATE_LOW]) begin
      return `TWS_HALF_RATE1;
    end
    return `TWS_HALF_RATE0;
  endfunction : half_of

  tws_dev_state_t q;
  tws_dev_state_t d;

  logic serial_sel;
  logic master;
  logic alt_phase;
  logic busy;
  logic psw_wr;
  logic rise;
  logic fall;

  assign serial_sel = q.ctrl[`TWS_CTRL_SERIAL_SEL];
  assign master = q.pin_cfg[`TWS_PIN_SHIFT_CLOCK];
  assign alt_phase = q.pin_cfg[`TWS_PIN_PHASE_SEL];
  assign busy = q.processor_status_word[`TWS_PSW_BUSY];
  assign psw_wr = wr && (addr == `TWS_OFF_PSW);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    rise = 1'b0;
    fall = 1'b0;
    // pin inputs pass three flops; edges only look past the first
    d.sk_s1 = link.sk_line;
    d.sk_s2 = q.sk_s1;
    d.sk_s3 = q.sk_s2;
    d.si_s1 = link.dev_si_line;
    d.si_s2 = q.si_s1;
    d.si_s3 = q.si_s2;

    // register reads, data one cycle later
    d.rdata = `TWS_RST_BYTE;
    if (rd) begin
      unique case (addr)
        `TWS_OFF_PIN_DATA: d.rdata = q.pin_data;
        `TWS_OFF_PIN_CFG: d.rdata = q.pin_cfg;
        `TWS_OFF_SHIFT: d.rdata = q.shift_reg;
        `TWS_OFF_CTRL: d.rdata = q.ctrl;
        `TWS_OFF_PSW: d.rdata = q.processor_status_word;
        `TWS_OFF_IRQ_STATUS: d.rdata = q.irq_sts;
        `TWS_OFF_IRQ_ENABLE: d.rdata = q.irq_en;
        default: d.rdata = `TWS_RST_BYTE;
      endcase
    end

    // register writes
    if (wr) begin
      unique case (addr)
        `TWS_OFF_PIN_DATA: d.pin_data = wdata;
        `TWS_OFF_PIN_CFG: d.pin_cfg = wdata;
        // loading while the clock is high is the user's fault
        `TWS_OFF_SHIFT: d.shift_reg = wdata;
        `TWS_OFF_CTRL: d.ctrl = wdata;
        `TWS_OFF_PSW: d.processor_status_word = wdata;
        `TWS_OFF_IRQ_CLEAR: d.irq_sts = q.irq_sts & ~wdata;
        `TWS_OFF_IRQ_ENABLE: d.irq_en = wdata;
        default: d = d;
      endcase
    end

    if (psw_wr) begin
      // a fresh start or an early stop restarts the bit count
      if (!wdata[`TWS_PSW_BUSY] || !busy) begin
        d.bits = 4'h0;
        d.div = 3'h0;
        d.sk_int = 1'b0;
      end
    end else if (busy && serial_sel) begin
      if (master) begin
        // internal clock, only this end starts an exchange
        if (q.div == half_of(q.ctrl) - 3'h1) begin
          d.div = 3'h0;
          d.sk_int = !q.sk_int;
          rise = !q.sk_int;
          fall = q.sk_int;
        end else begin
          d.div = q.div + 3'h1;
        end
        // sample where our own pin rise is seen, in step with the far end's lag
        if (q.sk_s2 && !q.sk_s3 && !alt_phase) begin
          d.smp = q.si_s2;
        end
      end else begin
        // external clock seen through the synchroniser
        rise = q.sk_s2 && !q.sk_s3;
        fall = !q.sk_s2 && q.sk_s3;
      end
      if (rise) begin
        // as slave take the bit from before the edge: the master moves on it
        if (alt_phase) begin
          d.shift_reg = {q.shift_reg[6:0], master ? q.si_s2 : q.si_s3};
        end else if (!master) begin
          d.smp = q.si_s3;
        end
      end
      if (fall) begin
        if (!alt_phase) begin
          d.shift_reg = {q.shift_reg[6:0], q.smp};
        end
        d.bits = q.bits + 4'h1;
        if (q.bits == `TWS_BITS_PER_XFER - 4'h1) begin
          d.processor_status_word[`TWS_PSW_BUSY] = 1'b0;
          d.irq_sts[`TWS_IRQ_DONE] = 1'b1;
          d.bits = 4'h0;
        end
      end
    end else begin
      d.sk_int = 1'b0;
      d.div = 3'h0;
    end

    d.irq = |(d.irq_sts & d.irq_en);

    // ----------------------------------------
    // pin routing
    // ----------------------------------------
    if (d.ctrl[`TWS_CTRL_SERIAL_SEL]) begin
      d.so_o = d.shift_reg[7];
      d.so_oe_n = !d.pin_cfg[`TWS_PIN_SERIAL_OUT];
      d.sk_o = d.sk_int;
      d.sk_oe_n = !d.pin_cfg[`TWS_PIN_SHIFT_CLOCK];
    end else begin
      d.so_o = d.pin_data[`TWS_PIN_SERIAL_OUT];
      d.so_oe_n = !d.pin_cfg[`TWS_PIN_SERIAL_OUT];
      d.sk_o = d.pin_data[`TWS_PIN_SHIFT_CLOCK];
      d.sk_oe_n = !d.pin_cfg[`TWS_PIN_SHIFT_CLOCK];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.so_oe_n <= 1'b1;
      q.sk_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign irq = q.irq;
  assign link.dev_so_o = q.so_o;
  assign link.dev_so_oe_n = q.so_oe_n;
  assign link.dev_sk_o = q.sk_o;
  assign link.dev_sk_oe_n = q.sk_oe_n;
endmodule : tws_device

// File: core/tws_partner.sv
`timescale 1ns/100ps
`include "tws_map.svh"
module tws_partner (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // user side
  input wire logic master_mode,
  input wire logic alt_phase,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  // link
  tws_if.part link
);
  import tws_pkg::*;

  tws_part_state_t q;
  tws_part_state_t d;
  logic rise;
  logic fall;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    rise = 1'b0;
    fall = 1'b0;
    d.done = 1'b0;
    d.sk_s1 = link.sk_line;
    d.sk_s2 = q.sk_s1;
    d.sk_s3 = q.sk_s2;
    d.si_s1 = link.part_si_line;
    d.si_s2 = q.si_s1;
    d.si_s3 = q.si_s2;

    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.shift_reg = tx_byte;
      d.bits = 4'h0;
      d.div = 3'h0;
      d.sk_int = 1'b0;
    end else if (q.busy) begin
      if (master_mode) begin
        if (q.div == `TWS_PART_HALF - 3'h1) begin
          d.div = 3'h0;
          d.sk_int = !q.sk_int;
          rise = !q.sk_int;
          fall = q.sk_int;
        end else begin
          d.div = q.div + 3'h1;
        end
      end else begin
        // we must hold busy before the device's first edge arrives
        rise = q.sk_s2 && !q.sk_s3;
        fall = !q.sk_s2 && q.sk_s3;
      end
      if (rise) begin
        if (alt_phase) begin
          d.shift_reg = {q.shift_reg[6:0], master_mode ? q.si_s2 : q.si_s3};
        end else begin
          d.smp = master_mode ? q.si_s2 : q.si_s3;
        end
      end
      if (fall) begin
        if (!alt_phase) begin
          d.shift_reg = {q.shift_reg[6:0], q.smp};
        end
        d.bits = q.bits + 4'h1;
        if (q.bits == `TWS_BITS_PER_XFER - 4'h1) begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.rx = d.shift_reg;
          d.bits = 4'h0;
        end
      end
    end else begin
      d.sk_int = 1'b0;
    end

    d.so_o = d.shift_reg[7];
    d.sk_o = d.sk_int;
    d.sk_oe_n = !master_mode;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.sk_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;
  assign rx_byte = q.rx;
  assign link.part_so_o = q.so_o;
  assign link.part_so_oe_n = 1'b0;
  assign link.part_sk_o = q.sk_o;
  assign link.part_sk_oe_n = q.sk_oe_n;
endmodule : tws_partner

// File: shared/tws_if.sv
`timescale 1ns/100ps
interface tws_if;
  logic dev_sk_o;
  logic dev_sk_oe_n;
  logic dev_so_o;
  logic dev_so_oe_n;
  logic part_sk_o;
  logic part_sk_oe_n;
  logic part_so_o;
  logic part_so_oe_n;
  logic sk_line;
  logic dev_si_line;
  logic part_si_line;

  // undriven lines are pulled low, so the shift clock rests low
  assign sk_line = !dev_sk_oe_n ? dev_sk_o : (!part_sk_oe_n ? part_sk_o : 1'b0);
  assign dev_si_line = !part_so_oe_n ? part_so_o : 1'b0;
  assign part_si_line = !dev_so_oe_n ? dev_so_o : 1'b0;

  modport dev (
    output dev_sk_o, dev_sk_oe_n, dev_so_o, dev_so_oe_n,
    input sk_line, dev_si_line
  );
  modport part (
    output part_sk_o, part_sk_oe_n, part_so_o, part_so_oe_n,
    input sk_line, part_si_line
  );
endinterface : tws_if

// File: shared/tws_map.svh
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TWS_OFF_PIN_DATA 8'hD4
`define TWS_OFF_PIN_CFG 8'hD5
`define TWS_OFF_SHIFT 8'hE9
`define TWS_OFF_CTRL 8'hEE
`define TWS_OFF_PSW 8'hEF
`define TWS_OFF_IRQ_STATUS 8'hE0
`define TWS_OFF_IRQ_CLEAR 8'hE1
`define TWS_OFF_IRQ_ENABLE 8'hE2

// ----------------------------------------
// field positions
// ----------------------------------------
`define TWS_CTRL_RATE_LOW 0
`define TWS_CTRL_RATE_HIGH 1
`define TWS_CTRL_SERIAL_SEL 3
`define TWS_PSW_BUSY 2
`define TWS_PIN_SERIAL_OUT 4
`define TWS_PIN_SHIFT_CLOCK 5
`define TWS_PIN_PHASE_SEL 6
`define TWS_IRQ_DONE 0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TWS_RST_BYTE 8'h00
`define TWS_BITS_PER_XFER 4'h8
`define TWS_HALF_RATE0 3'h1
`define TWS_HALF_RATE1 3'h2
`define TWS_HALF_RATE2 3'h4
`define TWS_PART_HALF 3'h6

`endif

// File: shared/tws_pkg.sv
package tws_pkg;

  // ----------------------------------------
  // state of the device end
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] pin_data;
    logic [7:0] pin_cfg;
    logic [7:0] shift_reg;
    logic [7:0] ctrl;
    logic [7:0] processor_status_word;
    logic [7:0] irq_en;
    logic [7:0] irq_sts;
    logic [7:0] rdata;
    logic irq;
    logic sk_int;
    logic [2:0] div;
    logic [3:0] bits;
    logic smp;
    logic sk_s1;
    logic sk_s2;
    logic sk_s3;
    logic si_s1;
    logic si_s2;
    logic si_s3;
    logic so_o;
    logic so_oe_n;
    logic sk_o;
    logic sk_oe_n;
  } tws_dev_state_t;

  // ----------------------------------------
  // state of the partner end
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] shift_reg;
    logic [7:0] rx;
    logic busy;
    logic done;
    logic sk_int;
    logic [2:0] div;
    logic [3:0] bits;
    logic smp;
    logic sk_s1;
    logic sk_s2;
    logic sk_s3;
    logic si_s1;
    logic si_s2;
    logic si_s3;
    logic so_o;
    logic sk_o;
    logic sk_oe_n;
  } tws_part_state_t;

endpackage : tws_pkg

// File: tb/test_three_wire_serial_shifter.sv
`timescale 1ns/100ps
`include "tws_map.svh"
module test_three_wire_serial_shifter;
  import tws_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic master_mode = 1'b0, alt_phase = 1'b0, start = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, tx_byte = 8'h00, rdata, rx_byte, v;
  logic irq, busy, done;
  logic [7:0] sent_q[$];
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  tws_if tws_if_i ();
  tws_device tws_device_i (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .link(tws_if_i.dev));
  tws_partner tws_partner_i (.clock(clock), .arst_n(arst_n), .master_mode(master_mode), .alt_phase(alt_phase),
    .start(start), .tx_byte(tx_byte), .busy(busy), .done(done), .rx_byte(rx_byte), .link(tws_if_i.part));
  tws_props tws_props_i (.clock(clock), .arst_n(arst_n), .dev_sk_o(tws_if_i.dev_sk_o),
    .dev_sk_oe_n(tws_if_i.dev_sk_oe_n), .dev_so_o(tws_if_i.dev_so_o), .dev_so_oe_n(tws_if_i.dev_so_oe_n),
    .part_sk_o(tws_if_i.part_sk_o), .part_sk_oe_n(tws_if_i.part_sk_oe_n), .part_so_o(tws_if_i.part_so_o),
    .part_so_oe_n(tws_if_i.part_so_oe_n), .sk_line(tws_if_i.sk_line), .dev_si_line(tws_if_i.dev_si_line),
    .part_si_line(tws_if_i.part_si_line));
  // ----
  // clock, timeout, bus tasks
  // ----
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // called right after a rising edge; one idle cycle after each access
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask : reg_wr
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask : reg_rd
  task automatic pstart();
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask : pstart
  // ----
  // one byte exchange; m: device is master
  // ----
  // fast: rate too quick for a synchronised slave to answer, its reply is not compared
  task automatic xfer(logic m, logic ph, logic [1:0] rt, logic en, logic ab, logic fast);
    logic [7:0] db, pb;
    db = 8'($urandom);
    pb = 8'($urandom);
    alt_phase <= ph;
    tx_byte <= pb;
    // release the clock pin before the partner may take it
    reg_wr(`TWS_OFF_PIN_CFG, {1'b0, ph, 1'b0, 1'b1, 4'h0});
    master_mode <= !m;
    reg_wr(`TWS_OFF_PIN_CFG, {1'b0, ph, m, 1'b1, 4'h0});
    reg_wr(`TWS_OFF_CTRL, 8'h08 | {6'h00, rt});
    reg_wr(`TWS_OFF_IRQ_ENABLE, {7'h00, en});
    reg_wr(`TWS_OFF_SHIFT, db);
    if (m) pstart();
    reg_wr(`TWS_OFF_PSW, 8'h04);
    if (!m) pstart();
    if (ab) begin
      repeat (20) @(posedge clock);
      reg_wr(`TWS_OFF_PSW, 8'h00);
      reg_rd(`TWS_OFF_PSW, v);
      chk("abort busy", 8'h00, v & 8'h04);
      reg_rd(`TWS_OFF_IRQ_STATUS, v);
      chk("abort status", 8'h00, v);
      chk("abort clock", 8'h00, {7'h00, tws_if_i.sk_line});
      return;
    end
    sent_q.push_back(db);
    v = 8'h04;
    for (int i = 0; i < 300 && (busy || v[2]); i++) reg_rd(`TWS_OFF_PSW, v);
    chk("busy", 8'h00, v & 8'h04);
    reg_rd(`TWS_OFF_SHIFT, v);
    if (!fast) chk("dev rx", pb, v);
    chk("part rx", sent_q.pop_front(), rx_byte);
    reg_rd(`TWS_OFF_IRQ_STATUS, v);
    chk("status", 8'h01, v);
    chk("irq", {7'h00, en}, {7'h00, irq});
    reg_wr(`TWS_OFF_IRQ_CLEAR, 8'h01);
    reg_rd(`TWS_OFF_IRQ_STATUS, v);
    chk("cleared", 8'h00, v);
    chk("irq low", 8'h00, {7'h00, irq});
  endtask : xfer
  initial begin
    void'($urandom(57128));
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    reg_rd(`TWS_OFF_PIN_CFG, v);
    chk("pin cfg", 8'h00, v);
    reg_rd(`TWS_OFF_PSW, v);
    chk("psw", 8'h00, v);
    reg_rd(8'h00, v);
    chk("unmapped", 8'h00, v);
    for (int k = 0; k < 12; k++) begin
      xfer(k[0], k[1], {k[0] | 1'($urandom), 1'($urandom)}, k[2], 1'b0, 1'b0);
    end
    xfer(1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 1'b1);
    xfer(1'b1, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
    xfer(1'b1, 1'b0, 2'h2, 1'b1, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule : test_three_wire_serial_shifter

// File: tb/tws_props.sv
`timescale 1ns/100ps
// ----
// link checks
// ----
module tws_props (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // link
  input wire logic dev_sk_o,
  input wire logic dev_sk_oe_n,
  input wire logic dev_so_o,
  input wire logic dev_so_oe_n,
  input wire logic part_sk_o,
  input wire logic part_sk_oe_n,
  input wire logic part_so_o,
  input wire logic part_so_oe_n,
  input wire logic sk_line,
  input wire logic dev_si_line,
  input wire logic part_si_line
);
  logic [3:0] hi_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // length of the current high run, so slow rates show up
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 4'h0;
    end else begin
      hi_q <= sk_line ? hi_q + 4'h1 : 4'h0;
    end
  end
  sk_one_driver_a: assert property (!(!dev_sk_oe_n && !part_sk_oe_n))
    else $error("both ends drive the shift clock");
  sk_idle_low_a: assert property ((dev_sk_oe_n && part_sk_oe_n) |-> !sk_line)
    else $error("undriven shift clock not low");
  sk_take_low_a: assert property ($fell(dev_sk_oe_n) |-> !dev_sk_o)
    else $error("device takes the clock pin high");
  sk_drive_a: assert property (!dev_sk_oe_n |-> sk_line == dev_sk_o)
    else $error("device clock not on the line");
  dev_half_a: assert property ((sk_line && !dev_sk_oe_n) |-> hi_q <= 4'h3)
    else $error("device clock high too long");
  part_half_a: assert property ($rose(sk_line) && !part_sk_oe_n |-> sk_line [*6] ##1 !sk_line)
    else $error("partner half period wrong");
  so_route_a: assert property (!dev_so_oe_n |-> part_si_line == dev_so_o)
    else $error("serial out not routed");
  so_float_a: assert property (dev_so_oe_n |-> !part_si_line)
    else $error("released serial out not low");
  si_route_a: assert property (!part_so_oe_n |-> dev_si_line == part_so_o)
    else $error("serial in not routed");
endmodule : tws_props
